// ---- hdl/qcsio_pkg.sv ----
`default_nettype none
package qcsio_pkg;
   // operation and frequency modes
   typedef enum logic [1:0] {
      QCSIO_OP_NORMAL,
      QCSIO_OP_QUICK,
      QCSIO_OP_SWEEP,
      QCSIO_OP_OTHER
   } qcsio_op_mode_t;

   typedef enum logic [1:0] {
      QCSIO_FREQ_INTERNAL,
      QCSIO_FREQ_EXT_SYNC,
      QCSIO_FREQ_SWEEP,
      QCSIO_FREQ_QUICK
   } qcsio_freq_mode_t;

   // current ranges of the test set and of the amplifier
   typedef enum logic [1:0] {
      QCSIO_RANGE_0A4,
      QCSIO_RANGE_4A,
      QCSIO_RANGE_20A,
      QCSIO_RANGE_NONE
   } qcsio_range_t;

   // timing
   localparam int QCSIO_CLK_HZ = 25_000_000;
   localparam int QCSIO_SETTLE_MS = 1000;
   localparam int QCSIO_SETTLE_CYC = QCSIO_CLK_HZ / 1000 * QCSIO_SETTLE_MS;
   localparam int QCSIO_CNT_W = 32;
   localparam int QCSIO_PHASE_W = 16;
   localparam logic [QCSIO_CNT_W-1:0] QCSIO_CNT_ZERO = 32'h0000_0000;
   localparam logic [QCSIO_CNT_W-1:0] QCSIO_CNT_ONE = 32'h0000_0001;
   localparam logic [QCSIO_PHASE_W-1:0] QCSIO_PHASE_ZERO = 16'h0000;
   localparam logic [QCSIO_PHASE_W-1:0] QCSIO_PHASE_HALF = 16'h8000;
endpackage
`default_nettype wire

// ---- hdl/qcsio_top.sv ----
// Operation
// - sync output falls exactly at zero phase of the internal waveform
// - falling edge on sync input marks zero phase when following outside
// - lock to sync input only in external sync frequency mode
// - allow about one second of settling before frequency counts stable
// - external sync inhibits frequency sweep and frequency quick change
// - quick-change fault transitions act only in quick-change mode
// - direct command output low while quick change runs, high otherwise
// - after direct output falls, wait pre-trigger then fault start phase
// - delayed command output low from fault switch-over while fault lasts
// - external start input begins a quick-change sequence
// - command input held low forces fault, skipping pre-trigger delay
// - amplifier range: 4A to 4A, 20A to 20A, 0.4A refused
`timescale 1ns/1ps
`default_nettype none
module qcsio_top
   import qcsio_pkg::*;
#(
   parameter int SETTLE_CYC = QCSIO_SETTLE_CYC
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   // mode settings
   input wire qcsio_pkg::qcsio_op_mode_t op_mode_in,
   input wire qcsio_pkg::qcsio_freq_mode_t freq_mode_in,
   input wire logic sync_out_en_in,
   // synthesizer phase accumulator increment
   input wire logic [qcsio_pkg::QCSIO_PHASE_W-1:0] phase_step_in,
   // quick-change settings and controls
   input wire logic [qcsio_pkg::QCSIO_CNT_W-1:0] pretrig_cyc_in,
   input wire logic [qcsio_pkg::QCSIO_PHASE_W-1:0] fault_phase_in,
   input wire logic qc_start_in,
   input wire logic qc_stop_in,
   // pins from the partner
   input wire logic sync_pin_in,
   input wire logic ext_start_pin_in,
   input wire logic qc_cmd_pin_in,
   // amplifier range request
   input wire qcsio_pkg::qcsio_range_t range_in,
   // pins to the partner
   output logic sync_pin_out,
   output logic qc_direct_n_out,
   output logic qc_delay_n_out,
   output var qcsio_pkg::qcsio_range_t amp_range_out,
   // status to the synthesizer core
   output logic [qcsio_pkg::QCSIO_PHASE_W-1:0] phase_out,
   output logic fault_out,
   output logic freq_stable_out,
   output logic sweep_inhibit_out,
   output logic range_error_out
);
   import qcsio_pkg::*;

   typedef enum logic [1:0] {
      QCSIO_IDLE,
      QCSIO_PRETRIG,
      QCSIO_WAIT_PHASE,
      QCSIO_FAULT
   } qcsio_state_t;

   ////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic [1:0] rst_sync;
   logic rst_n;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // pins are idle high; the first stage feeds only the second
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic sync_prev;
   logic start_prev;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 3'h7;
         pin_s2 <= 3'h7;
         sync_prev <= 1'b1;
         start_prev <= 1'b1;
      end else begin
         pin_s1 <= {qc_cmd_pin_in, ext_start_pin_in, sync_pin_in};
         pin_s2 <= pin_s1;
         sync_prev <= pin_s2[0];
         start_prev <= pin_s2[1];
      end
   end

   wire sync_fall = sync_prev & ~pin_s2[0];
   wire ext_start = start_prev & ~pin_s2[1];
   wire cmd_low = ~pin_s2[2];

   ////////////////////////////////////////////////////////////////////////
   // phase generation and frequency sync
   wire ext_sync = (freq_mode_in == QCSIO_FREQ_EXT_SYNC);
   logic [QCSIO_PHASE_W-1:0] phase;
   logic [QCSIO_PHASE_W-1:0] phase_sum;
   logic [QCSIO_PHASE_W-1:0] next_phase;
   logic [QCSIO_PHASE_W-1:0] prev_phase;
   assign phase_sum = phase + phase_step_in;
   // restarting at zero on each outside edge is a phase lock, not a pll;
   // frequency jitter of the partner passes straight through
   assign next_phase = (ext_sync && sync_fall) ? QCSIO_PHASE_ZERO
                                               : phase_sum;
   // wrap of the accumulator is the zero-degree point
   wire wrap = (phase_sum < phase) || (ext_sync && sync_fall);
   wire next_sync_out = (phase_sum >= QCSIO_PHASE_HALF) | sync_pin_out;

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         phase <= QCSIO_PHASE_ZERO;
         prev_phase <= QCSIO_PHASE_ZERO;
         sync_pin_out <= 1'b1;
      end else begin
         phase <= next_phase;
         prev_phase <= phase;
         // falls only at the wrap and rises in the upper half, so enabling
         // the output in the low half cannot make a false zero edge
         sync_pin_out <= sync_out_en_in ? (wrap ? 1'b0 : next_sync_out)
                                        : 1'b1;
      end
   end
   assign phase_out = phase;

   ////////////////////////////////////////////////////////////////////////
   // settling timer
   wire sync_used = ext_sync | sync_out_en_in;
   logic sync_used_q;
   logic [QCSIO_CNT_W-1:0] settle_cnt;
   wire sync_begin = sync_used & ~sync_used_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_used_q <= 1'b0;
         settle_cnt <= QCSIO_CNT_ZERO;
      end else begin
         sync_used_q <= sync_used;
         if (sync_begin) begin
            settle_cnt <= SETTLE_CYC[QCSIO_CNT_W-1:0];
         end else if (settle_cnt != QCSIO_CNT_ZERO) begin
            settle_cnt <= settle_cnt - QCSIO_CNT_ONE;
         end
      end
   end
   assign freq_stable_out = (settle_cnt == QCSIO_CNT_ZERO) & ~sync_begin;
   assign sweep_inhibit_out = ext_sync;

   ////////////////////////////////////////////////////////////////////////
   // quick-change sequencer
   wire qc_mode = (op_mode_in == QCSIO_OP_QUICK);
   // frequency quick change is blocked under external sync
   wire qc_allowed = qc_mode & ~ext_sync;
   wire start_req = qc_allowed & (qc_start_in | ext_start);
   wire force_fault = qc_allowed & cmd_low;
   wire phase_hit = (prev_phase < fault_phase_in) &&
                    (phase >= fault_phase_in);

   qcsio_state_t state;
   qcsio_state_t next_state;
   logic [QCSIO_CNT_W-1:0] pre_cnt;

   always_comb begin
      next_state = state;
      unique case (state)
         QCSIO_IDLE: begin
            if (force_fault) begin
               next_state = QCSIO_FAULT;
            end else if (start_req) begin
               next_state = QCSIO_PRETRIG;
            end
         end
         QCSIO_PRETRIG: begin
            if (force_fault) begin
               next_state = QCSIO_FAULT;
            end else if (pre_cnt == QCSIO_CNT_ZERO) begin
               next_state = QCSIO_WAIT_PHASE;
            end
         end
         QCSIO_WAIT_PHASE: begin
            if (force_fault || phase_hit) begin
               next_state = QCSIO_FAULT;
            end
         end
         QCSIO_FAULT: begin
            if (qc_stop_in && !force_fault) begin
               next_state = QCSIO_IDLE;
            end
         end
      endcase
      if (!qc_allowed) begin
         next_state = QCSIO_IDLE;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= QCSIO_IDLE;
         pre_cnt <= QCSIO_CNT_ZERO;
      end else begin
         state <= next_state;
         if (state == QCSIO_IDLE) begin
            pre_cnt <= pretrig_cyc_in;
         end else if (pre_cnt != QCSIO_CNT_ZERO) begin
            pre_cnt <= pre_cnt - QCSIO_CNT_ONE;
         end
      end
   end

   // the delayed output can drive a companion directly, which then must
   // run with its own delays disabled to switch together with us
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         qc_direct_n_out <= 1'b1;
         qc_delay_n_out <= 1'b1;
         fault_out <= 1'b0;
      end else begin
         qc_direct_n_out <= (next_state == QCSIO_IDLE);
         qc_delay_n_out <= (next_state != QCSIO_FAULT);
         fault_out <= (next_state == QCSIO_FAULT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // amplifier range mapping
   wire range_bad = (range_in == QCSIO_RANGE_0A4) ||
                    (range_in == QCSIO_RANGE_NONE);
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         amp_range_out <= QCSIO_RANGE_NONE;
         range_error_out <= 1'b0;
      end else begin
         amp_range_out <= range_bad ? QCSIO_RANGE_NONE : range_in;
         range_error_out <= range_bad;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   direct_tracks_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (!qc_direct_n_out && !qc_stop_in && qc_allowed) |=>
      !qc_direct_n_out)
      else $error("direct command output rose while the sequence ran");
   delay_fault_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      $fell(qc_delay_n_out) |-> $past(force_fault) ||
      ($past(state) == QCSIO_WAIT_PHASE && $past(phase_hit)))
      else $error("delayed command output fell outside a fault entry");
   seq_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (fault_out && qc_stop_in && !force_fault) |=>
      (qc_direct_n_out && qc_delay_n_out && !fault_out))
      else $error("command outputs not released at sequence end");
   ext_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state == QCSIO_IDLE && ext_start && qc_allowed && !force_fault) |=>
      !qc_direct_n_out)
      else $error("external start pin did not begin the sequence");
   force_fault_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      force_fault |=> fault_out)
      else $error("command input low did not force fault");
   mode_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      !qc_allowed |=> qc_direct_n_out && qc_delay_n_out)
      else $error("quick change acted outside quick-change mode");
   pretrig_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state == QCSIO_PRETRIG && pre_cnt != QCSIO_CNT_ZERO && !force_fault
       && qc_allowed) |=> !fault_out)
      else $error("fault entered before pre-trigger time");
   start_seq_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state == QCSIO_IDLE && start_req && !force_fault) |=>
      !qc_direct_n_out && qc_delay_n_out)
      else $error("start did not begin the sequence");
   sync_lock_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (ext_sync && sync_fall) |=> phase == QCSIO_PHASE_ZERO)
      else $error("phase not reset at input falling edge");
   no_lock_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      !ext_sync |=> phase == $past(phase_sum))
      else $error("phase locked outside external sync mode");
   settle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      sync_begin |=> !freq_stable_out)
      else $error("frequency stable without settling time");
   settle_run_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      settle_cnt != QCSIO_CNT_ZERO |-> !freq_stable_out)
      else $error("frequency stable while settling");
   range_map_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      range_in == QCSIO_RANGE_0A4 |=> range_error_out)
      else $error("0.4A range not refused");
   range_pass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (range_in == QCSIO_RANGE_4A || range_in == QCSIO_RANGE_20A) |=>
      (amp_range_out == $past(range_in) && !range_error_out))
      else $error("4A or 20A range not passed to the amplifier");
   sync_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (sync_out_en_in && wrap) |=> !sync_pin_out)
      else $error("sync output not low at zero phase");
   zero_fall_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      $fell(sync_pin_out) |->
      (phase < phase_step_in || phase == QCSIO_PHASE_ZERO))
      else $error("sync output fell away from zero phase");
endmodule
`default_nettype wire

// ---- verif/qcsio_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module qcsio_partner (
   // clock
   input wire logic clk_in,
   // pins from the device and reference enable
   input wire logic delay_n_in,
   input wire logic ref_en_in,
   // pins to the device and status
   output logic sync_pin_out,
   output logic fault_out
);
   logic [4:0] cnt;
   // own pre-trigger and fault phase are off, so fault follows at once
   assign fault_out = ~delay_n_in;
   // reference runs 20 cycles a period, unrelated to the 16-step wrap
   always_ff @(posedge clk_in) begin
      if (!ref_en_in) begin
         cnt <= 5'h00;
         sync_pin_out <= 1'b1;
      end else if (cnt == 5'h09) begin
         cnt <= 5'h00;
         sync_pin_out <= ~sync_pin_out;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qcsio_pkg::*;
   logic sys_clk_in, rstn_in, sync_out_en_in, qc_start_in, qc_stop_in;
   logic ext_start_pin_in, qc_cmd_pin_in, ref_en, sync_pin_in, peer_fault;
   qcsio_op_mode_t op_mode_in;
   qcsio_freq_mode_t freq_mode_in;
   qcsio_range_t range_in, amp_range_out;
   logic [15:0] phase_step_in, fault_phase_in, phase_out;
   logic [31:0] pretrig_cyc_in;
   logic sync_pin_out, qc_direct_n_out, qc_delay_n_out, fault_out;
   logic freq_stable_out, sweep_inhibit_out, range_error_out;
   int mismatches = 0;
   int check_count = 0;
   qcsio_top #(.SETTLE_CYC(50)) i_dut (.sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in), .op_mode_in(op_mode_in),
      .freq_mode_in(freq_mode_in), .sync_out_en_in(sync_out_en_in),
      .phase_step_in(phase_step_in), .pretrig_cyc_in(pretrig_cyc_in),
      .fault_phase_in(fault_phase_in), .qc_start_in(qc_start_in),
      .qc_stop_in(qc_stop_in), .sync_pin_in(sync_pin_in),
      .ext_start_pin_in(ext_start_pin_in), .qc_cmd_pin_in(qc_cmd_pin_in),
      .range_in(range_in), .sync_pin_out(sync_pin_out),
      .qc_direct_n_out(qc_direct_n_out), .qc_delay_n_out(qc_delay_n_out),
      .amp_range_out(amp_range_out), .phase_out(phase_out),
      .fault_out(fault_out), .freq_stable_out(freq_stable_out),
      .sweep_inhibit_out(sweep_inhibit_out),
      .range_error_out(range_error_out));
   qcsio_partner i_peer (.clk_in(sys_clk_in), .delay_n_in(qc_delay_n_out),
      .ref_en_in(ref_en), .sync_pin_out(sync_pin_in), .fault_out(peer_fault));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: %s", $time, what);
      end
   endtask
   task automatic pulse_start();
      qc_start_in = 1'b1;
      step(1);
      qc_start_in = 1'b0;
   endtask
   // stop pulse, then both command outputs must be back high
   task automatic end_seq();
      qc_stop_in = 1'b1;
      step(1);
      qc_stop_in = 1'b0;
      step(2);
      chk({14'h0, qc_direct_n_out, qc_delay_n_out}, 16'h0003, "lines");
      chk({15'h0, fault_out}, 16'h0000, "fault left");
   endtask
   task automatic wait_fault();
      for (int i = 0; i < 40 && fault_out !== 1'b1; i++) step(1);
      chk({15'h0, fault_out}, 16'h0001, "fault reached");
      chk({15'h0, qc_delay_n_out}, 16'h0000, "delay low");
      chk({15'h0, peer_fault}, 16'h0001, "peer fault");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_quick();
      pulse_start();
      step(1);
      chk({15'h0, qc_direct_n_out}, 16'h0000, "direct low");
      chk({15'h0, qc_delay_n_out}, 16'h0001, "delay early");
      step(3);
      chk({15'h0, fault_out}, 16'h0000, "fault early");
      wait_fault();
      end_seq();
      $display("test quick done");
   endtask
   task automatic t_refuse();
      op_mode_in = QCSIO_OP_NORMAL;
      pulse_start();
      step(3);
      chk({15'h0, qc_direct_n_out}, 16'h0001, "normal start");
      op_mode_in = QCSIO_OP_QUICK;
      freq_mode_in = QCSIO_FREQ_EXT_SYNC;
      step(1);
      chk({15'h0, sweep_inhibit_out}, 16'h0001, "inhibit");
      pulse_start();
      step(3);
      chk({15'h0, qc_direct_n_out}, 16'h0001, "ext sync start");
      freq_mode_in = QCSIO_FREQ_INTERNAL;
      step(2);
      $display("test refuse done");
   endtask
   task automatic t_ext_start();
      ext_start_pin_in = 1'b0;
      step(6);
      chk({15'h0, qc_direct_n_out}, 16'h0000, "ext direct");
      wait_fault();
      ext_start_pin_in = 1'b1;
      end_seq();
      $display("test ext start done");
   endtask
   task automatic t_cmd();
      qc_cmd_pin_in = 1'b0;
      step(5);
      chk({14'h0, fault_out, qc_delay_n_out}, 16'h0002, "forced");
      qc_cmd_pin_in = 1'b1;
      step(5);
      chk({14'h0, fault_out, qc_delay_n_out}, 16'h0002, "held");
      end_seq();
      $display("test command done");
   endtask
   // falling sync edge must land on the wrap of the accumulator
   task automatic t_sync();
      logic [15:0] p;
      sync_out_en_in = 1'b1;
      step(3);
      chk({15'h0, freq_stable_out}, 16'h0000, "settling");
      for (int i = 0; i < 40 && sync_pin_out !== 1'b1; i++) step(1);
      for (int i = 0; i < 40 && sync_pin_out !== 1'b0; i++) step(1);
      chk({15'h0, sync_pin_out}, 16'h0000, "out fell");
      chk(phase_out, 16'h0000, "out zero");
      step(60);
      chk({15'h0, freq_stable_out}, 16'h0001, "settled");
      // an outside edge while running free must not move the phase
      ref_en = 1'b1;
      for (int i = 0; i < 40 && sync_pin_in !== 1'b0; i++) step(1);
      p = phase_out;
      step(4);
      chk(phase_out, p + 16'h4000, "free run");
      freq_mode_in = QCSIO_FREQ_EXT_SYNC;
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 40 && sync_pin_in !== 1'b1; i++) step(1);
         for (int i = 0; i < 40 && sync_pin_in !== 1'b0; i++) step(1);
         step(4);
         chk({15'h0, phase_out < 16'h7000}, 16'h0001, "in zero");
      end
      ref_en = 1'b0;
      freq_mode_in = QCSIO_FREQ_INTERNAL;
      sync_out_en_in = 1'b0;
      step(2);
      $display("test sync done");
   endtask
   task automatic t_range();
      qcsio_range_t req [4] = '{QCSIO_RANGE_0A4, QCSIO_RANGE_4A,
         QCSIO_RANGE_20A, QCSIO_RANGE_NONE};
      qcsio_range_t exp [4] = '{QCSIO_RANGE_NONE, QCSIO_RANGE_4A,
         QCSIO_RANGE_20A, QCSIO_RANGE_NONE};
      logic err [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         range_in = req[i];
         step(2);
         chk({14'h0, amp_range_out}, {14'h0, exp[i]}, "range");
         chk({15'h0, range_error_out}, {15'h0, err[i]}, "refused");
      end
      $display("test range done");
   endtask
   // reset in the middle of a sequence, then a clean sequence again
   task automatic t_reset();
      pulse_start();
      step(2);
      chk({15'h0, qc_direct_n_out}, 16'h0000, "running");
      rstn_in = 1'b0;
      step(2);
      chk({13'h0, qc_direct_n_out, qc_delay_n_out, fault_out}, 16'h0006,
          "reset");
      rstn_in = 1'b1;
      step(4);
      t_quick();
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      rstn_in = 1'b0;
      op_mode_in = QCSIO_OP_QUICK;
      freq_mode_in = QCSIO_FREQ_INTERNAL;
      sync_out_en_in = 1'b0;
      phase_step_in = 16'h1000;
      pretrig_cyc_in = 32'h0000_0004;
      fault_phase_in = 16'h4000;
      qc_start_in = 1'b0;
      qc_stop_in = 1'b0;
      ext_start_pin_in = 1'b1;
      qc_cmd_pin_in = 1'b1;
      range_in = QCSIO_RANGE_4A;
      ref_en = 1'b0;
      step(4);
      rstn_in = 1'b1;
      step(4);
      t_quick();
      t_refuse();
      t_ext_start();
      t_cmd();
      t_sync();
      t_range();
      t_reset();
      stop_test();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      mismatches++;
      stop_test();
   end
endmodule
`default_nettype wire
